// *** logic/phy_ext_ctrl_regs.sv ***
// extended control and status register bank with interrupt logic
`timescale 1ns/1ps
`include "phy_ext_ctrl_defines.svh"
module phy_ext_ctrl_regs
    import phy_ext_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    // register port
    input  wire logic [7:0]   reg_addr_in,
    input  wire logic [15:0]  reg_wdata_in,
    input  wire logic         reg_write_in,
    input  wire logic         reg_read_in,
    output logic      [15:0]  reg_rdata_out,
    // self-test generator
    output logic      [10:0]  selftest_packet_length_out,
    // cable diagnostic engine
    output logic              diag_start_out,
    input  wire logic         diag_done_in,
    input  wire logic         diag_fail_in,
    input  wire logic [1:0]   link_quality_in,
    // device reset and restart
    output logic              soft_reset_out,
    output logic              soft_restart_out,
    // transmit clock phase
    output phase_move_s       phase_move_out,
    // regulator
    output logic              regulator_power_down_out,
    output logic      [3:0]   regulator_ctrl_out,
    // interrupt
    output logic              irq_out
);

    // ----------------------------------------
    // register map, word addressed
    // ----------------------------------------
    // 1c  packet length in 10:0, upper bits read zero
    // 1e  start 15, quality 9:8, done 1, fail 0
    // 1f  soft reset 15 and restart 14, self-clearing
    // 42  shift enable 4 (self-clearing), phase 3:0
    // d0  power-down 15, spare 14:4, control 3:0
    // e0  interrupt status, a written one clears
    // e1  interrupt mask, a one lets the bit through
    // unmapped reads return zero, unmapped writes vanish
    // read data stand for one cycle, zero otherwise,
    // so a bus that samples late sees zero, not stale data

    // ----------------------------------------
    // helpers
    // ----------------------------------------

    // wrap a written phase back into 0..10
    function automatic logic [3:0] phase_wrap(input logic [3:0] v);
        if (v > `PHASE_MODULUS) begin
            phase_wrap = v - `PHASE_MODULUS;
        end else begin
            phase_wrap = v;
        end
    endfunction

    // value that every register takes after any reset
    function automatic bank_state_s reset_state();
        bank_state_s r;
        r               = '0;
        r.pkt_len       = `SELFTEST_LEN_RESET;
        r.phase.value   = `PHASE_RESET;
        return r;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    bank_state_s st_reg;   // registered state
    bank_state_s st_next;  // next state
    logic        wr_len;   // write decodes
    logic        wr_diag;
    logic        wr_rst;
    logic        wr_phase;
    logic        wr_vr;
    logic        wr_ists;
    logic        wr_imsk;
    logic        done_rise; // completion edge from the engine
    logic        fail_rise; // failure edge from the engine
    logic [3:0]  new_phase; // wrapped write value
    logic [2:0]  events;    // interrupt sources this cycle

    // ----------------------------------------
    // write decode
    // ----------------------------------------

    // a write lands in one cycle, no wait states
    assign wr_len   = reg_write_in && (reg_addr_in == `ADDR_SELFTEST_LEN);
    assign wr_diag  = reg_write_in && (reg_addr_in == `ADDR_CABLE_DIAG);
    assign wr_rst   = reg_write_in && (reg_addr_in == `ADDR_SOFT_RESET);
    assign wr_phase = reg_write_in && (reg_addr_in == `ADDR_TX_PHASE);
    assign wr_vr    = reg_write_in && (reg_addr_in == `ADDR_REGULATOR);
    assign wr_ists  = reg_write_in && (reg_addr_in == `ADDR_IRQ_STATUS);
    assign wr_imsk  = reg_write_in && (reg_addr_in == `ADDR_IRQ_MASK);

    // engine inputs share this clock, so no synchroniser
    assign done_rise = diag_done_in && !st_reg.diag_done;
    assign fail_rise = diag_fail_in && !st_reg.diag_fail;
    assign new_phase = phase_wrap(reg_wdata_in[3:0]);

    // ----------------------------------------
    // next state
    // ----------------------------------------

    // all register behaviour in one place
    always_comb begin
        st_next               = st_reg;
        st_next.sreset_pulse  = 1'b0;
        st_next.restart_pulse = 1'b0;
        st_next.phase.pulse   = 1'b0;
        st_next.rdata         = 16'h0000;
        events                = 3'b000;

        // packet length, upper bits dropped
        if (wr_len) begin
            st_next.pkt_len = reg_wdata_in[10:0];
        end

        // diagnostic flags track the engine
        st_next.diag_done = diag_done_in;
        st_next.diag_fail = diag_fail_in;
        st_next.quality   = link_quality_in;
        if (wr_diag) begin
            // zero here stops a running measurement
            st_next.diag_start = reg_wdata_in[`DIAG_START_BIT];
        end
        // completion edge wins over a simultaneous start write
        if (done_rise) begin
            st_next.diag_start = 1'b0;
        end

        // reset and restart requests
        if (wr_rst) begin
            st_next.sreset_pend   = reg_wdata_in[`SRESET_BIT];
            st_next.restart_pulse = reg_wdata_in[`RESTART_BIT];
        end

        // phase is only moved when the enable rides with the write
        // a write without the enable is dropped, not parked, so a
        // later enable alone cannot replay a stale value; ten stays
        // ten, eleven and up wrap down by ten
        if (wr_phase && reg_wdata_in[`PHASE_EN_BIT]) begin
            st_next.phase.pulse = 1'b1;
            st_next.phase.value = new_phase;
            // steps of the phase unit, sign carried in bit 4
            st_next.phase.delta = {1'b0, new_phase} - {1'b0, st_reg.phase.value};
        end

        // regulator: power-down latches until the next reset
        // limitation: nothing but a reset powers it up again,
        // which keeps a stray zero write from waking it
        if (wr_vr) begin
            st_next.vr_resv = reg_wdata_in[14:4];
            st_next.vr_ctrl = reg_wdata_in[3:0];
            if (reg_wdata_in[`PWR_DOWN_BIT]) begin
                st_next.vr_pd = 1'b1;
            end
        end

        // interrupt sources: set beats write-one-to-clear
        // status 0 done rise, 1 fail rise, 2 phase applied
        // irq follows next state, so a mask or clear write
        // moves the level at the same edge as the register
        events[`IRQ_DONE_BIT]  = done_rise;
        events[`IRQ_FAIL_BIT]  = fail_rise;
        events[`IRQ_PHASE_BIT] = st_next.phase.pulse;
        if (wr_ists) begin
            st_next.irq_status = st_reg.irq_status & ~reg_wdata_in[2:0];
        end
        st_next.irq_status = st_next.irq_status | events;
        if (wr_imsk) begin
            st_next.irq_mask = reg_wdata_in[2:0];
        end
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        // read data stand only in the cycle after the strobe
        if (reg_read_in) begin
            case (reg_addr_in)
                `ADDR_SELFTEST_LEN: begin
                    st_next.rdata = {5'h00, st_reg.pkt_len};
                end
                `ADDR_CABLE_DIAG: begin
                    st_next.rdata = {st_reg.diag_start, 5'h00, st_reg.quality, 6'h00,
                                     st_reg.diag_done, st_reg.diag_fail};
                end
                `ADDR_SOFT_RESET: begin
                    // self-clearing bits are already back at zero
                    st_next.rdata = 16'h0000;
                end
                `ADDR_TX_PHASE: begin
                    st_next.rdata = {12'h000, st_reg.phase.value};
                end
                `ADDR_REGULATOR: begin
                    st_next.rdata = {1'b0, st_reg.vr_resv, st_reg.vr_ctrl};
                end
                `ADDR_IRQ_STATUS: begin
                    st_next.rdata = {13'h0000, st_reg.irq_status};
                end
                `ADDR_IRQ_MASK: begin
                    st_next.rdata = {13'h0000, st_reg.irq_mask};
                end
                default: begin
                    // unmapped reads return zero
                    st_next.rdata = 16'h0000;
                end
            endcase
        end

        // soft reset, counted from the edge taking the write:
        //   edge 0 sets the pending flag
        //   edge 1 loads reset values and raises the pulse
        //   edge 2 drops the pulse
        // a bus access in the pending cycle is lost on purpose,
        // the bank reset loads at the same edge that would take it anyway
        // pin reset, or soft reset one cycle after its write
        if (!resetn_in) begin
            st_next = reset_state();
        end else if (st_reg.sreset_pend) begin
            st_next              = reset_state();
            st_next.sreset_pulse = 1'b1;
        end
    end

    // single state register, synchronous reset handled above
    always_ff @(posedge clk_in) begin
        st_reg <= st_next;
    end

    // ----------------------------------------
    // outputs, straight from the state register
    // ----------------------------------------
    assign reg_rdata_out              = st_reg.rdata;
    assign selftest_packet_length_out = st_reg.pkt_len;
    assign diag_start_out             = st_reg.diag_start;
    assign soft_reset_out             = st_reg.sreset_pulse;
    assign soft_restart_out           = st_reg.restart_pulse;
    assign phase_move_out             = st_reg.phase;
    assign regulator_power_down_out   = st_reg.vr_pd;
    assign regulator_ctrl_out         = st_reg.vr_ctrl;
    assign irq_out                    = st_reg.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // all checks sleep while the pin reset is low; those that
    // look one edge ahead, other than chk_phase_resv_zero, chk_rst_reg_zero,
    // chk_rdata_idle and chk_soft_reset_seq, also skip the soft reset pending cycle,
    // whose bank reset overrides the normal paths

    // soft reset write, then pending cycle, then reset pulse
    sequence s_sreset_write;
        reg_write_in && reg_addr_in == `ADDR_SOFT_RESET && reg_wdata_in[`SRESET_BIT];
    endsequence
    sequence s_sreset_done;
        soft_reset_out && selftest_packet_length_out == `SELFTEST_LEN_RESET && !diag_start_out;
    endsequence
    // read of the diagnostic register outside a soft reset
    sequence s_diag_read;
        reg_read_in && reg_addr_in == `ADDR_CABLE_DIAG && !st_reg.sreset_pend;
    endsequence

    chk_len_after_reset: assert property (
        $rose(resetn_in) |-> selftest_packet_length_out == `SELFTEST_LEN_RESET)
        else $error("packet length not at reset value");

    chk_len_resv_zero: assert property (
        reg_read_in && reg_addr_in == `ADDR_SELFTEST_LEN && !st_reg.sreset_pend
        |=> reg_rdata_out[15:11] == 5'h00 && reg_rdata_out[10:0] == $past(selftest_packet_length_out))
        else $error("packet length readback wrong");

    chk_start_clears: assert property (
        diag_start_out && diag_done_in && !st_reg.diag_done && !st_reg.sreset_pend |=> !diag_start_out)
        else $error("start bit survived done edge");

    chk_done_readback: assert property (
        reg_read_in && reg_addr_in == `ADDR_CABLE_DIAG && !st_reg.sreset_pend
        |=> reg_rdata_out[`DIAG_DONE_BIT] == $past(diag_done_in, 2))
        else $error("done flag readback wrong");

    chk_fail_readback: assert property (
        reg_read_in && reg_addr_in == `ADDR_CABLE_DIAG && !st_reg.sreset_pend
        |=> reg_rdata_out[`DIAG_FAIL_BIT] == $past(diag_fail_in, 2))
        else $error("fail flag readback wrong");

    chk_quality_readback: assert property (
        reg_read_in && reg_addr_in == `ADDR_CABLE_DIAG && !st_reg.sreset_pend
        |=> reg_rdata_out[9:8] == $past(link_quality_in, 2))
        else $error("link quality readback wrong");

    chk_soft_reset_seq: assert property (
        s_sreset_write |-> ##2 s_sreset_done ##1 !soft_reset_out)
        else $error("soft reset did not reset the bank");

    chk_restart_keeps: assert property (
        reg_write_in && reg_addr_in == `ADDR_SOFT_RESET && reg_wdata_in[`RESTART_BIT]
        && !reg_wdata_in[`SRESET_BIT] && !st_reg.sreset_pend
        |=> soft_restart_out && $stable(selftest_packet_length_out) ##1 !soft_restart_out)
        else $error("restart pulse wrong or registers lost");

    chk_phase_wrap: assert property (
        wr_phase && reg_wdata_in[`PHASE_EN_BIT] && reg_wdata_in[3:0] > 4'ha && !st_reg.sreset_pend
        |=> phase_move_out.value == $past(reg_wdata_in[3:0]) - 4'ha)
        else $error("phase not wrapped modulo ten");

    chk_phase_delta: assert property (
        phase_move_out.pulse
        |-> 5'(phase_move_out.value) - phase_move_out.delta == 5'($past(phase_move_out.value)))
        else $error("phase move not equal to difference");

    chk_phase_hold: assert property (
        wr_phase && !reg_wdata_in[`PHASE_EN_BIT] && !st_reg.sreset_pend
        |=> !phase_move_out.pulse && $stable(phase_move_out.value))
        else $error("phase moved without enable");

    chk_vr_power_down: assert property (
        wr_vr && reg_wdata_in[`PWR_DOWN_BIT] && !st_reg.sreset_pend
        |=> regulator_power_down_out [*2])
        else $error("regulator not powered down");

    chk_len_write: assert property (
        wr_len && !st_reg.sreset_pend
        |=> selftest_packet_length_out == $past(reg_wdata_in[10:0]))
        else $error("packet length write not taken");

    chk_diag_resv_zero: assert property (
        s_diag_read |=> reg_rdata_out[14:10] == 5'h00 && reg_rdata_out[7:2] == 6'h00)
        else $error("diagnostic reserved bits not zero");

    chk_phase_resv_zero: assert property (
        reg_read_in && reg_addr_in == `ADDR_TX_PHASE |=> reg_rdata_out[15:4] == 12'h000)
        else $error("phase reserved bits not zero");

    chk_start_set: assert property (
        wr_diag && reg_wdata_in[`DIAG_START_BIT] && !done_rise && !st_reg.sreset_pend |=> diag_start_out)
        else $error("start bit not set by write");

    chk_start_stop: assert property (
        wr_diag && !reg_wdata_in[`DIAG_START_BIT] && !st_reg.sreset_pend |=> !diag_start_out)
        else $error("start bit not cleared by zero write");

    chk_done_irq: assert property (
        done_rise && !st_reg.sreset_pend |=> st_reg.irq_status[`IRQ_DONE_BIT])
        else $error("done rise not latched");

    chk_fail_irq: assert property (
        fail_rise && !st_reg.sreset_pend |=> st_reg.irq_status[`IRQ_FAIL_BIT])
        else $error("fail rise not latched");

    chk_rst_reg_zero: assert property (
        reg_read_in && reg_addr_in == `ADDR_SOFT_RESET |=> reg_rdata_out == 16'h0000)
        else $error("self-clearing bits read back set");

    chk_phase_range: assert property (
        phase_move_out.value <= `PHASE_MODULUS)
        else $error("phase value above ten");

    chk_vr_on_reset: assert property (
        $rose(resetn_in) |-> !regulator_power_down_out)
        else $error("regulator off after reset");

    chk_rdata_idle: assert property (
        !reg_read_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not zero when idle");

endmodule

// *** logic/phy_ext_ctrl_defines.svh ***
// constants for the extended control register bank: offsets, fields, resets, timing
// Behaviour
// - packet length field, resets to 1500
// - reserved read-only bits read zero, ignore writes; regulator bits 14:4 are stored and read back
// - start bit runs diagnostic, clears on done
// - done flag set when measurement completes
// - fail flag set when measurement fails
// - link quality field: 01 good, 10 mid, 11 poor
// - soft reset bit acts as hardware reset
// - restart bit reinitialises, keeps register contents
// - phase offset counted in 4 ns steps
// - phase written above ten stored modulo ten
// - clock moves by step times value difference
// - shift enable applies phase, zero leaves it
// - phase field reads offset in effect, resets zero
// - regulator power-down bit switches regulator off
`ifndef PHY_EXT_CTRL_DEFINES_SVH
`define PHY_EXT_CTRL_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_SELFTEST_LEN   8'h1c
`define ADDR_CABLE_DIAG     8'h1e
`define ADDR_SOFT_RESET     8'h1f
`define ADDR_TX_PHASE       8'h42
`define ADDR_REGULATOR      8'hd0
`define ADDR_IRQ_STATUS     8'he0
`define ADDR_IRQ_MASK       8'he1
// ----------------------------------------
// field positions
// ----------------------------------------
`define DIAG_START_BIT      15
`define DIAG_DONE_BIT       1
`define DIAG_FAIL_BIT       0
`define SRESET_BIT          15
`define RESTART_BIT         14
`define PHASE_EN_BIT        4
`define PWR_DOWN_BIT        15
`define IRQ_DONE_BIT        0
`define IRQ_FAIL_BIT        1
`define IRQ_PHASE_BIT       2
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SELFTEST_LEN_RESET  11'h5dc
`define PHASE_RESET         4'h0
`define PHASE_MODULUS       4'ha
`define PHASE_STEP_NS       4
`endif

// *** logic/phy_ext_ctrl_pkg.sv ***
// types shared by the extended control register bank
package phy_ext_ctrl_pkg;
    // phase move request toward the transmit clock generator
    typedef struct packed {
        logic       pulse;   // one cycle per applied shift
        logic [4:0] delta;   // signed steps, new minus old
        logic [3:0] value;   // phase now in effect
    } phase_move_s;
    // whole state of the register bank
    typedef struct packed {
        logic [10:0] pkt_len;
        logic        diag_start;
        logic        diag_done;
        logic        diag_fail;
        logic [1:0]  quality;
        logic        sreset_pend;
        logic        sreset_pulse;
        logic        restart_pulse;
        phase_move_s phase;
        logic        vr_pd;
        logic [10:0] vr_resv;
        logic [3:0]  vr_ctrl;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic        irq;
        logic [15:0] rdata;
    } bank_state_s;
endpackage

// *** bench/phy_ext_ctrl_regs_tb_top.sv ***
// self-checking bench for the extended control register bank
`timescale 1ns/1ps
`include "phy_ext_ctrl_defines.svh"
module phy_ext_ctrl_regs_tb_top
    import phy_ext_ctrl_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk_in;           // 40 mhz bench clock
    logic        resetn_in;        // synchronous, active low
    logic [7:0]  reg_addr_in;      // register address
    logic [15:0] reg_wdata_in;     // write data
    logic        reg_write_in;     // write strobe
    logic        reg_read_in;      // read strobe
    logic [15:0] reg_rdata_out;    // read data, cycle after strobe
    logic [10:0] pkt_len_out;      // length to self-test generator
    logic        diag_start_out;   // run level to diagnostic engine
    logic        diag_done_in;     // engine done level
    logic        diag_fail_in;     // engine fail level
    logic [1:0]  link_quality_in;  // engine quality code
    logic        soft_reset_out;   // device reset pulse
    logic        soft_restart_out; // restart pulse
    phase_move_s phase_move_out;   // phase shift request
    logic        vr_pd_out;        // regulator off
    logic [3:0]  vr_ctrl_out;      // regulator control field
    logic        irq_out;          // level interrupt
    int          n_mismatch;       // failed comparisons
    int          n_checks;         // comparisons made
    int          cycles;           // timeout counter

    phy_ext_ctrl_regs i_phy_ext_ctrl_regs (
        .clk_in                    (clk_in),
        .resetn_in                 (resetn_in),
        .reg_addr_in               (reg_addr_in),
        .reg_wdata_in              (reg_wdata_in),
        .reg_write_in              (reg_write_in),
        .reg_read_in               (reg_read_in),
        .reg_rdata_out             (reg_rdata_out),
        .selftest_packet_length_out(pkt_len_out),
        .diag_start_out            (diag_start_out),
        .diag_done_in              (diag_done_in),
        .diag_fail_in              (diag_fail_in),
        .link_quality_in           (link_quality_in),
        .soft_reset_out            (soft_reset_out),
        .soft_restart_out          (soft_restart_out),
        .phase_move_out            (phase_move_out),
        .regulator_power_down_out  (vr_pd_out),
        .regulator_ctrl_out        (vr_ctrl_out),
        .irq_out                   (irq_out)
    );

    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    always #12.5 clk_in = ~clk_in;

    // the whole run is about 110 cycles, so 3000 means a hang
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write, returns just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
        #1;
    endtask

    // one-cycle read, data looked at in the cycle after the strobe only
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        #1;
        check(what, exp, reg_rdata_out);
    endtask

    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        resetn_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 16'h0000;
        reg_write_in = 1'b0;
        reg_read_in = 1'b0;
        diag_done_in = 1'b0;
        diag_fail_in = 1'b0;
        link_quality_in = 2'h0;
        n_mismatch = 0;
        n_checks = 0;
        cycles = 0;
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1;
        // reset values and plain access
        check("len out", 16'h05dc, 16'(pkt_len_out));
        rd(`ADDR_SELFTEST_LEN, 16'h05dc, "len reg");
        rd(`ADDR_TX_PHASE, 16'h0000, "phase reset");
        rd(8'h50, 16'h0000, "unmapped");
        wr(`ADDR_SELFTEST_LEN, 16'hffff);
        check("len out max", 16'h07ff, 16'(pkt_len_out));
        rd(`ADDR_SELFTEST_LEN, 16'h07ff, "len resv");
        wr(`ADDR_SELFTEST_LEN, 16'h0040);
        rd(`ADDR_SELFTEST_LEN, 16'h0040, "len reg");
        // every quality code reaches the read data, link taken as up
        for (int q = 1; q < 4; q++) begin
            @(posedge clk_in);
            link_quality_in <= 2'(q);
            rd(`ADDR_CABLE_DIAG, {6'h00, 2'(q), 8'h00}, "quality");
        end
        // diagnostic handshake
        wr(`ADDR_CABLE_DIAG, 16'h8000);
        check("start", 16'h0001, 16'(diag_start_out));
        rd(`ADDR_CABLE_DIAG, 16'h8300, "diag run");
        @(posedge clk_in);
        diag_done_in <= 1'b1;
        tick();
        check("start done", 16'h0000, 16'(diag_start_out));
        rd(`ADDR_CABLE_DIAG, 16'h0302, "diag done");
        @(posedge clk_in);
        diag_fail_in <= 1'b1;
        rd(`ADDR_CABLE_DIAG, 16'h0303, "diag fail");
        wr(`ADDR_CABLE_DIAG, 16'h7fff);
        rd(`ADDR_CABLE_DIAG, 16'h0303, "diag resv");
        @(posedge clk_in);
        diag_done_in <= 1'b0;
        diag_fail_in <= 1'b0;
        // interrupt: masked, unmasked, cleared
        rd(`ADDR_IRQ_STATUS, 16'h0003, "irq status");
        check("irq masked", 16'h0000, 16'(irq_out));
        wr(`ADDR_IRQ_MASK, 16'h0002);
        tick();
        check("irq on", 16'h0001, 16'(irq_out));
        wr(`ADDR_IRQ_STATUS, 16'h0002);
        tick();
        check("irq clr", 16'h0000, 16'(irq_out));
        rd(`ADDR_IRQ_STATUS, 16'h0001, "irq left");
        // phase moves: pulse, delta in steps, value in effect
        wr(`ADDR_TX_PHASE, 16'h0012);
        check("phase 2", 16'h0222, 16'(phase_move_out));
        tick();
        check("phase hold", 16'h0022, 16'(phase_move_out));
        wr(`ADDR_TX_PHASE, 16'h0019);
        check("phase 9", 16'h0279, 16'(phase_move_out));
        rd(`ADDR_TX_PHASE, 16'h0009, "phase rd");
        wr(`ADDR_TX_PHASE, 16'h001d);
        check("phase 13", 16'h03a3, 16'(phase_move_out));
        wr(`ADDR_TX_PHASE, 16'h000c);
        tick();
        check("phase no en", 16'h01a3, 16'(phase_move_out));
        rd(`ADDR_TX_PHASE, 16'h0003, "phase kept");
        wr(`ADDR_TX_PHASE, 16'h001a);
        check("phase 10", 16'h027a, 16'(phase_move_out));
        wr(`ADDR_TX_PHASE, 16'h001f);
        check("phase 15", 16'h03b5, 16'(phase_move_out));
        wr(`ADDR_IRQ_MASK, 16'h0004);
        tick();
        check("irq phase", 16'h0001, 16'(irq_out));
        wr(`ADDR_IRQ_STATUS, 16'h0004);
        tick();
        check("irq phase clr", 16'h0000, 16'(irq_out));
        // regulator off stays off until reset
        rd(`ADDR_REGULATOR, 16'h0000, "vr reset");
        wr(`ADDR_REGULATOR, 16'h8005);
        check("vr off", 16'h0015, {11'h000, vr_pd_out, vr_ctrl_out});
        rd(`ADDR_REGULATOR, 16'h0005, "vr reg");
        wr(`ADDR_REGULATOR, 16'h0003);
        check("vr kept", 16'h0013, {11'h000, vr_pd_out, vr_ctrl_out});
        // restart pulses once and keeps registers
        wr(`ADDR_SOFT_RESET, 16'h4000);
        check("restart", 16'h0001, 16'(soft_restart_out));
        tick();
        check("restart end", 16'h0000, 16'(soft_restart_out));
        rd(`ADDR_SELFTEST_LEN, 16'h0040, "len kept");
        rd(`ADDR_SOFT_RESET, 16'h0000, "sc bits");
        // soft reset: one pending cycle, then a one-cycle pulse
        wr(`ADDR_SOFT_RESET, 16'h8000);
        check("sreset pend", 16'h0000, 16'(soft_reset_out));
        tick();
        check("sreset", 16'h0001, 16'(soft_reset_out));
        tick();
        check("sreset end", 16'h0000, 16'(soft_reset_out));
        check("vr after", 16'h0000, {11'h000, vr_pd_out, vr_ctrl_out});
        rd(`ADDR_SELFTEST_LEN, 16'h05dc, "len after");
        rd(`ADDR_TX_PHASE, 16'h0000, "phase after");
        rd(`ADDR_IRQ_MASK, 16'h0000, "mask after");
        end_of_test();
    end
endmodule
